// File: hdl/adtp_consts.vh
`ifndef ADTP_CONSTS_VH
`define ADTP_CONSTS_VH

// bus widths
`define ADTP_DATA_W          16
`define ADTP_ADDR_W          8
`define ADTP_BYTE_W          8

// register offsets
`define ADTP_OFS_PORT_SETUP  8'h00
`define ADTP_OFS_BURST_LAST  8'h02
`define ADTP_OFS_DIE_ID      8'h08
`define ADTP_OFS_OUT_MODE_A  8'h73
`define ADTP_OFS_RATE_MODE   8'h74
`define ADTP_OFS_CLK_STATUS  8'h75
`define ADTP_OFS_PATT_SEL    8'hc0
`define ADTP_OFS_W1_LOW      8'hc2
`define ADTP_OFS_W1_HIGH     8'hc3
`define ADTP_OFS_W2_LOW      8'hc4
`define ADTP_OFS_W2_HIGH     8'hc5

// reset values
`define ADTP_RST_BYTE        8'h00
`define ADTP_RST_WORD        16'h0000

// field positions
`define ADTP_BIT_SOFT_RST    5
`define ADTP_BIT_DLL_SLOW    6
`define ADTP_BIT_DDR_EN      4
`define ADTP_FMT_HI          2
`define ADTP_FMT_LO          0
`define ADTP_OMODE_HI        7
`define ADTP_OMODE_LO        5
`define ADTP_UMODE_HI        7
`define ADTP_UMODE_LO        6
`define ADTP_PCODE_HI        3
`define ADTP_PCODE_LO        0

// output coding select values
`define ADTP_FMT_PIN         3'h0
`define ADTP_FMT_TWOS        3'h1
`define ADTP_FMT_GRAY        3'h2
`define ADTP_FMT_OFFS        3'h4

// coding pin encodings
`define ADTP_PIN_TWOS        2'h0
`define ADTP_PIN_GRAY        2'h1
`define ADTP_PIN_OFFS        2'h2

// user test modes
`define ADTP_UMODE_STATIC    2'h0
`define ADTP_UMODE_ALT       2'h1

// pattern codes
`define ADTP_PC_OFF          4'h0
`define ADTP_PC_MID          4'h1
`define ADTP_PC_POS          4'h2
`define ADTP_PC_NEG          4'h3
`define ADTP_PC_CHECK        4'h4
`define ADTP_PC_ONEZERO      4'h7
`define ADTP_PC_USER         4'h8

// preset words
`define ADTP_W_MID           16'h8000
`define ADTP_W_ONES          16'hffff
`define ADTP_W_ZEROS         16'h0000
`define ADTP_W_CHECK_A       16'haaaa
`define ADTP_W_CHECK_B       16'h5555

// test enable settling stages
`define ADTP_SYNC_STAGES     2

`endif

// File: hdl/adtp_coder.v
`timescale 1ns/100ps
`default_nettype none
`include "adtp_consts.vh"

// offset-binary sample recoded to the selected format
module adtp_coder #(
    parameter W = 16
) (
    input  wire [W-1:0] sample_in,
    input  wire [2:0]   fmt_sel,
    input  wire [1:0]   fmt_pin_sel,
    output reg  [W-1:0] coded_out
);

    reg [2:0] fmt_eff;

    always @* begin
        fmt_eff = fmt_sel;
        if (fmt_sel == `ADTP_FMT_PIN) begin
            case (fmt_pin_sel)
                `ADTP_PIN_TWOS: fmt_eff = `ADTP_FMT_TWOS;
                `ADTP_PIN_GRAY: fmt_eff = `ADTP_FMT_GRAY;
                default:        fmt_eff = `ADTP_FMT_OFFS;
            endcase
        end
        case (fmt_eff)
            `ADTP_FMT_TWOS: coded_out = {~sample_in[W-1], sample_in[W-2:0]};
            `ADTP_FMT_GRAY: coded_out = sample_in ^ (sample_in >> 1);
            default:        coded_out = sample_in;
        endcase
    end

endmodule
`default_nettype wire

// File: hdl/adtp_sync.v
`timescale 1ns/100ps
`default_nettype none
`include "adtp_consts.vh"

// settling stages for the test selection
module adtp_sync #(
    parameter W      = 6,
    parameter STAGES = 2
) (
    input  wire         clk,
    input  wire         arst_n,
    input  wire         ce,
    input  wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);

    reg [W*STAGES-1:0] pipe_reg;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pipe_reg <= {(W*STAGES){1'b0}};
        end else if (ce) begin
            pipe_reg <= {pipe_reg[W*(STAGES-1)-1:0], d_in};
        end
    end

    assign q_out = pipe_reg[W*STAGES-1 -: W];

endmodule
`default_nettype wire

// File: hdl/adtp_ctrl.v
// How it works
// - one-hot format field: 000 pin, 001 two's, 010 gray, 100 offset binary
// - status bit 6 picks loop range, fast after reset
// - status bit 4 set gives double data rate output
// - alternate mode swaps two words each cycle; static holds one word
// - test selection settles over several sample cycles before output
// - pattern bits 7:6 pick static 00 or alternate 01; others reserved
// - code 0 off, 1 midscale 8000, 2 all ones, 3 all zeros
// - code 4 checkerboard aaaa/5555, code 7 ones/zeros; 5,6 reserved
// - code 8 sends the two custom words as first and second words
// - first custom word: low byte at c2, high byte at c3
// - second custom word: low and high bytes up to c5
// - format and mode selections survive a soft register reset
`timescale 1ns/100ps
`default_nettype none
`include "adtp_consts.vh"

module adtp_ctrl #(
    parameter [7:0] DIE_ID = 8'h5a // arbitrary value
) (
    input  wire                      clk,
    input  wire                      arst_n,
    input  wire                      ce,
    input  wire [`ADTP_ADDR_W-1:0]   reg_addr,
    input  wire [`ADTP_BYTE_W-1:0]   reg_wdata,
    input  wire                      reg_wr,
    input  wire                      reg_rd,
    output reg  [`ADTP_BYTE_W-1:0]   reg_rdata,
    output reg                       reg_rvalid,
    input  wire [1:0]                fmt_pin_sel,
    input  wire [`ADTP_DATA_W-1:0]   sample_in,
    output reg  [`ADTP_DATA_W-1:0]   data_out,
    output reg                       test_active,
    output wire                      ddr_en,
    output wire                      dll_slow,
    output wire [2:0]                out_mode_sel,
    output wire                      lsb_first,
    output wire                      sdo_active,
    output wire [`ADTP_BYTE_W-1:0]   burst_last
);

    localparam DW = `ADTP_DATA_W;

    ////////////////////////////////////////////////////////////////////////
    // register storage

    reg  [7:0]    port_setup_reg;
    reg  [7:0]    burst_last_reg;
    reg  [7:0]    out_mode_a_reg;
    reg  [7:0]    rate_mode_reg;
    reg  [7:0]    clk_status_reg;
    reg  [7:0]    patt_sel_reg;
    reg  [7:0]    w1_low_reg;
    reg  [7:0]    w1_high_reg;
    reg  [7:0]    w2_low_reg;
    reg  [7:0]    w2_high_reg;
    reg           soft_rst_reg;

    wire          wr_port;
    wire          wr_burst;
    wire          wr_omode;
    wire          wr_rate;
    wire          wr_patt;
    wire          wr_w1l;
    wire          wr_w1h;
    wire          wr_w2l;
    wire          wr_w2h;
    wire [7:0]    rate_status_next;

    ////////////////////////////////////////////////////////////////////////
    // address decode

    assign wr_port  = reg_wr && (reg_addr == `ADTP_OFS_PORT_SETUP);
    assign wr_burst = reg_wr && (reg_addr == `ADTP_OFS_BURST_LAST);
    assign wr_omode = reg_wr && (reg_addr == `ADTP_OFS_OUT_MODE_A);
    assign wr_rate  = reg_wr && (reg_addr == `ADTP_OFS_RATE_MODE);
    assign wr_patt  = reg_wr && (reg_addr == `ADTP_OFS_PATT_SEL);
    assign wr_w1l   = reg_wr && (reg_addr == `ADTP_OFS_W1_LOW);
    assign wr_w1h   = reg_wr && (reg_addr == `ADTP_OFS_W1_HIGH);
    assign wr_w2l   = reg_wr && (reg_addr == `ADTP_OFS_W2_LOW);
    assign wr_w2h   = reg_wr && (reg_addr == `ADTP_OFS_W2_HIGH);

    // effective settings follow write ^ stored rate-mode ^ status
    assign rate_status_next = reg_wdata ^ rate_mode_reg ^ clk_status_reg;

    ////////////////////////////////////////////////////////////////////////
    // soft reset pulse, self clearing

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_rst_reg <= 1'b0;
        end else if (ce) begin
            soft_rst_reg <= wr_port && reg_wdata[`ADTP_BIT_SOFT_RST];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers cleared by soft reset

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            port_setup_reg <= `ADTP_RST_BYTE;
            burst_last_reg <= `ADTP_RST_BYTE;
            patt_sel_reg   <= `ADTP_RST_BYTE;
            w1_low_reg     <= `ADTP_RST_BYTE;
            w1_high_reg    <= `ADTP_RST_BYTE;
            w2_low_reg     <= `ADTP_RST_BYTE;
            w2_high_reg    <= `ADTP_RST_BYTE;
        end else if (ce) begin
            if (soft_rst_reg) begin
                port_setup_reg <= `ADTP_RST_BYTE;
                burst_last_reg <= `ADTP_RST_BYTE;
                patt_sel_reg   <= `ADTP_RST_BYTE;
                w1_low_reg     <= `ADTP_RST_BYTE;
                w1_high_reg    <= `ADTP_RST_BYTE;
                w2_low_reg     <= `ADTP_RST_BYTE;
                w2_high_reg    <= `ADTP_RST_BYTE;
            end else begin
                if (wr_port) begin
                    port_setup_reg <= reg_wdata;
                end
                if (wr_burst) begin
                    burst_last_reg <= reg_wdata;
                end
                if (wr_patt) begin
                    patt_sel_reg <= reg_wdata;
                end
                if (wr_w1l) begin
                    w1_low_reg <= reg_wdata;
                end
                if (wr_w1h) begin
                    w1_high_reg <= reg_wdata;
                end
                if (wr_w2l) begin
                    w2_low_reg <= reg_wdata;
                end
                if (wr_w2h) begin
                    w2_high_reg <= reg_wdata;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers kept across soft reset

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_mode_a_reg <= `ADTP_RST_BYTE;
            rate_mode_reg  <= `ADTP_RST_BYTE;
            clk_status_reg <= `ADTP_RST_BYTE;
        end else if (ce) begin
            // no soft reset term here
            if (wr_omode) begin
                out_mode_a_reg <= reg_wdata;
            end
            if (wr_rate) begin
                rate_mode_reg  <= reg_wdata;
                clk_status_reg <= rate_status_next;
            end
        end
    end

    assign dll_slow     = clk_status_reg[`ADTP_BIT_DLL_SLOW];
    assign ddr_en       = clk_status_reg[`ADTP_BIT_DDR_EN];
    assign out_mode_sel = out_mode_a_reg[`ADTP_OMODE_HI:`ADTP_OMODE_LO];
    assign sdo_active   = port_setup_reg[7];
    assign lsb_first    = port_setup_reg[6];
    assign burst_last   = burst_last_reg;

    ////////////////////////////////////////////////////////////////////////
    // read port

    reg [7:0] rd_mux;

    always @* begin
        case (reg_addr)
            `ADTP_OFS_PORT_SETUP: rd_mux = port_setup_reg;
            `ADTP_OFS_BURST_LAST: rd_mux = burst_last_reg;
            `ADTP_OFS_DIE_ID:     rd_mux = DIE_ID;
            `ADTP_OFS_OUT_MODE_A: rd_mux = out_mode_a_reg;
            `ADTP_OFS_RATE_MODE:  rd_mux = rate_mode_reg;
            `ADTP_OFS_CLK_STATUS: rd_mux = clk_status_reg;
            `ADTP_OFS_PATT_SEL:   rd_mux = patt_sel_reg;
            `ADTP_OFS_W1_LOW:     rd_mux = w1_low_reg;
            `ADTP_OFS_W1_HIGH:    rd_mux = w1_high_reg;
            `ADTP_OFS_W2_LOW:     rd_mux = w2_low_reg;
            `ADTP_OFS_W2_HIGH:    rd_mux = w2_high_reg;
            default:              rd_mux = `ADTP_RST_BYTE;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata  <= `ADTP_RST_BYTE;
            reg_rvalid <= 1'b0;
        end else if (ce) begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // test selection settles before use

    wire [5:0] test_sel_raw;
    wire [5:0] test_sel;
    wire [1:0] umode;
    wire [3:0] pcode;

    assign test_sel_raw = {patt_sel_reg[`ADTP_UMODE_HI:`ADTP_UMODE_LO],
                           patt_sel_reg[`ADTP_PCODE_HI:`ADTP_PCODE_LO]};

    adtp_sync #(
        .W      (6),
        .STAGES (`ADTP_SYNC_STAGES)
    ) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .d_in   (test_sel_raw),
        .q_out  (test_sel)
    );

    assign umode = test_sel[5:4];
    assign pcode = test_sel[3:0];

    ////////////////////////////////////////////////////////////////////////
    // pattern word selection

    reg  [DW-1:0] word1;
    reg  [DW-1:0] word2;
    reg           has_word2;
    reg           patt_on;

    always @* begin
        word1     = `ADTP_W_ZEROS;
        word2     = `ADTP_W_ZEROS;
        has_word2 = 1'b0;
        patt_on   = 1'b1;
        case (pcode)
            `ADTP_PC_MID: begin
                word1 = `ADTP_W_MID;
            end
            `ADTP_PC_POS: begin
                word1 = `ADTP_W_ONES;
            end
            `ADTP_PC_NEG: begin
                word1 = `ADTP_W_ZEROS;
            end
            `ADTP_PC_CHECK: begin
                word1     = `ADTP_W_CHECK_A;
                word2     = `ADTP_W_CHECK_B;
                has_word2 = 1'b1;
            end
            `ADTP_PC_ONEZERO: begin
                word1     = `ADTP_W_ONES;
                word2     = `ADTP_W_ZEROS;
                has_word2 = 1'b1;
            end
            `ADTP_PC_USER: begin
                word1     = {w1_high_reg, w1_low_reg};
                word2     = {w2_high_reg, w2_low_reg};
                has_word2 = 1'b1;
            end
            default: begin
                patt_on = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // alternate phase

    reg        phase_reg;
    reg  [5:0] sel_seen_reg;
    wire       alt_run;
    wire       sel_change;

    assign alt_run = patt_on && has_word2 &&
                     (umode == `ADTP_UMODE_ALT);

    // a new selection always opens with the first word
    assign sel_change = (test_sel != sel_seen_reg);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_seen_reg <= 6'h00;
        end else if (ce) begin
            sel_seen_reg <= test_sel;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= 1'b0;
        end else if (ce) begin
            if (!alt_run) begin
                phase_reg <= 1'b0;
            end else if (sel_change) begin
                phase_reg <= 1'b1;
            end else begin
                phase_reg <= ~phase_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample coding and output bus

    wire [DW-1:0] coded;

    adtp_coder #(
        .W           (DW)
    ) u_coder (
        .sample_in   (sample_in),
        .fmt_sel     (out_mode_a_reg[`ADTP_FMT_HI:`ADTP_FMT_LO]),
        .fmt_pin_sel (fmt_pin_sel),
        .coded_out   (coded)
    );

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out    <= `ADTP_RST_WORD;
            test_active <= 1'b0;
        end else if (ce) begin
            test_active <= patt_on;
            if (!patt_on) begin
                data_out <= coded;
            end else if (alt_run && phase_reg && !sel_change) begin
                data_out <= word2;
            end else begin
                data_out <= word1;
            end
        end
    end

endmodule
`default_nettype wire

// File: bench/adtp_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module adtp_asserts #(
    parameter [7:0] DIE_ID = 8'h5a // arbitrary value
) (
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        ce,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic [15:0] data_out,
    input wire logic        test_active,
    input wire logic        ddr_en,
    input wire logic        dll_slow,
    input wire logic [2:0]  out_mode_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    sequence s_id_rd;
        ce && reg_rd && reg_addr == 8'h08;
    endsequence
    sequence s_mid_wr;
        ce && reg_wr && reg_addr == 8'hc0 && reg_wdata == 8'h01;
    endsequence
    sequence s_alt_wr;
        ce && reg_wr && reg_addr == 8'hc0 && reg_wdata == 8'h44;
    endsequence
    rvalid_pulse_a: assert property (ce && reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(ce && reg_rd))
        else $error("read answer without read");
    rdata_hold_a: assert property ($changed(reg_rdata) |-> reg_rvalid)
        else $error("read data moved without answer");
    die_read_a: assert property (s_id_rd |=> reg_rdata == DIE_ID)
        else $error("identifier read wrong");
    status_change_a: assert property (
        ($changed(ddr_en) || $changed(dll_slow))
        |-> $past(ce && reg_wr && reg_addr == 8'h74))
        else $error("status bits changed without rate write");
    mode_keep_a: assert property (
        $changed(out_mode_sel)
        |-> $past(ce && reg_wr && reg_addr == 8'h73))
        else $error("output mode changed without write");
    settle_delay_a: assert property (
        $rose(test_active)
        |-> $past(ce && reg_wr && reg_addr == 8'hc0, 4))
        else $error("test output started at wrong time");
    mid_word_a: assert property (
        s_mid_wr ##1 (ce && !reg_wr)[*4]
        |-> test_active && data_out == 16'h8000)
        else $error("midscale word missing");
    alt_words_a: assert property (
        s_alt_wr ##1 (ce && !reg_wr)[*5]
        |-> data_out == 16'h5555 && $past(data_out) == 16'haaaa)
        else $error("checkerboard words not alternating");
endmodule
bind adtp_ctrl adtp_asserts #(.DIE_ID(DIE_ID)) u_chk (.clk(clk),
    .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .data_out(data_out),
    .test_active(test_active), .ddr_en(ddr_en), .dll_slow(dll_slow),
    .out_mode_sel(out_mode_sel));
`default_nettype wire

// File: bench/adtp_host.sv
`timescale 1ns/100ps
`default_nettype none
module adtp_host (
    input wire logic       clk,
    input wire logic [7:0] reg_rdata,
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    output var logic       reg_wr,
    output var logic       reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one write strobe, lines inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // answer arrives at the same edge that takes the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        d = reg_rdata;
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
    // caller picks the range bit for its sample rate
    task automatic rmw(input logic [7:0] want);
        logic [7:0] b;
        logic [7:0] c;
        rd(8'h74, b);
        rd(8'h75, c);
        wr(8'h74, b ^ c ^ want);
    endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam logic [7:0] DIE = 8'h3c; // arbitrary value
    logic        clk, arst_n, ce, reg_wr, reg_rd, reg_rvalid, test_active;
    logic        ddr_en, dll_slow, lsb_first, sdo_active;
    logic [7:0]  burst_last;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, v, rate_exp, stat_exp;
    logic [1:0]  fmt_pin_sel;
    logic [2:0]  out_mode_sel;
    logic [15:0] sample_in, data_out, lf, w1, w2;
    logic [7:0]  rd_q[$];
    int          err_total, n_compared;
    logic [7:0]  zero_regs[9] = '{8'h00, 8'h02, 8'h74, 8'h75, 8'hc0,
                                   8'hc2, 8'hc4, 8'hc5, 8'h01};
    logic [7:0]  rw_regs[5] = '{8'h02, 8'hc2, 8'hc3, 8'hc4, 8'hc5};
    logic [7:0]  rates[4] = '{8'h10, 8'h50, 8'h00, 8'h40};
    logic [2:0]  fmts[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    adtp_ctrl #(.DIE_ID(DIE)) DUT (.clk(clk), .arst_n(arst_n), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .fmt_pin_sel(fmt_pin_sel), .sample_in(sample_in),
        .data_out(data_out), .test_active(test_active), .ddr_en(ddr_en),
        .dll_slow(dll_slow), .out_mode_sel(out_mode_sel),
        .lsb_first(lsb_first), .sdo_active(sdo_active),
        .burst_last(burst_last));
    adtp_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    always #5 clk = ~clk;
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] coded(input logic [15:0] s,
        input logic [2:0] f, input logic [1:0] p);
        logic [2:0] k;
        k = f;
        if (f == 3'h0) k = (p == 2'h0) ? 3'h1 : (p == 2'h1) ? 3'h2 : 3'h4;
        if (k == 3'h1) return s ^ 16'h8000;
        if (k == 3'h2) return s ^ (s >> 1);
        return s;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
        input string what);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // read answers matched against oldest note
    always @(negedge clk) begin
        if (reg_rvalid === 1'b1) begin
            if (rd_q.size() == 0) check({8'h00, reg_rdata}, 'x, "read data");
            else check({8'h00, reg_rdata}, {8'h00, rd_q.pop_front()}, "read");
        end
    end
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        host.rd(a, v);
    endtask
    task automatic pattern(input logic [7:0] code, input logic [15:0] a,
        input logic [15:0] b, input logic on);
        host.wr(8'hc0, code);
        repeat (3) @(posedge clk);
        #1;
        for (int i = 0; i < 4; i++) begin
            check({15'h0, test_active}, {15'h0, on}, "test active");
            check(data_out, i[0] ? b : a, "output word");
            @(posedge clk);
            #1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        ce = 1'b1;
        fmt_pin_sel = 2'h0;
        sample_in = 16'h0000;
        lf = 16'd25024;
        err_total = 0;
        n_compared = 0;
        rate_exp = 8'h00;
        stat_exp = 8'h00;
        repeat (3) @(posedge clk);
        #1;
        arst_n = 1'b1;
        foreach (zero_regs[i]) rd_chk(zero_regs[i], 8'h00);
        rd_chk(8'h08, DIE);
        foreach (rw_regs[i]) begin
            lf = lfsr(lf);
            host.wr(rw_regs[i], lf[7:0]);
            if (rw_regs[i] == 8'h02) begin
                check({8'h00, burst_last}, {8'h00, lf[7:0]}, "burst last");
            end
            rd_chk(rw_regs[i], lf[7:0]);
        end
        host.wr(8'h00, 8'hc0);
        check({14'h0, sdo_active, lsb_first}, 16'h0003, "port bits");
        host.wr(8'h08, 8'hff);
        rd_chk(8'h08, DIE);
        foreach (rates[i]) begin
            rd_q.push_back(rate_exp);
            rd_q.push_back(stat_exp);
            host.rmw(rates[i]);
            rate_exp = rate_exp ^ stat_exp ^ rates[i];
            stat_exp = rates[i];
            check({15'h0, ddr_en}, {15'h0, rates[i][4]}, "ddr");
            check({15'h0, dll_slow}, {15'h0, rates[i][6]}, "dll");
            rd_chk(8'h75, stat_exp);
        end
        foreach (fmts[i]) begin
            host.wr(8'h73, {5'h00, fmts[i]});
            for (int p = 0; p < 3; p++) begin
                fmt_pin_sel = p[1:0];
                lf = lfsr(lf);
                sample_in = lf;
                @(posedge clk);
                #1;
                check(data_out, coded(lf, fmts[i], p[1:0]), "coded");
            end
        end
        host.wr(8'h73, 8'h84);
        check({13'h0, out_mode_sel}, 16'h0004, "out mode");
        w1 = lfsr(lf);
        w2 = lfsr(w1);
        host.wr(8'hc2, w1[7:0]);
        host.wr(8'hc3, w1[15:8]);
        host.wr(8'hc4, w2[7:0]);
        host.wr(8'hc5, w2[15:8]);
        pattern(8'h01, 16'h8000, 16'h8000, 1'b1);
        pattern(8'h02, 16'hffff, 16'hffff, 1'b1);
        pattern(8'h03, 16'h0000, 16'h0000, 1'b1);
        pattern(8'h41, 16'h8000, 16'h8000, 1'b1);
        pattern(8'h44, 16'haaaa, 16'h5555, 1'b1);
        pattern(8'h47, 16'hffff, 16'h0000, 1'b1);
        pattern(8'h48, w1, w2, 1'b1);
        ce = 1'b0;
        repeat (3) begin
            @(posedge clk);
            #1;
            check(data_out, w1, "frozen word");
        end
        ce = 1'b1;
        @(posedge clk);
        #1;
        check(data_out, w2, "resumed word");
        pattern(8'h08, w1, w1, 1'b1);
        pattern(8'h45, lf, lf, 1'b0);
        pattern(8'h00, lf, lf, 1'b0);
        host.wr(8'h00, 8'h20);
        rd_chk(8'h73, 8'h84);
        rd_chk(8'h74, rate_exp);
        rd_chk(8'h75, stat_exp);
        rd_chk(8'hc0, 8'h00);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'hc2, 8'h00);
        check({13'h0, out_mode_sel}, 16'h0004, "kept mode");
        check({14'h0, sdo_active, lsb_first}, 16'h0000, "port cleared");
        repeat (2) @(posedge clk);
        #1;
        check(16'(rd_q.size()), 16'h0000, "unanswered reads");
        print_verdict();
    end
endmodule
`default_nettype wire
